// ### src/pfsr_top.sv
// program flash self-read controller with its special function registers
// Contract
// - array access happens in the second instruction cycle after the strobe
// - the second instruction after the strobe-setting one is discarded
// - the first instruction after the strobe executes normally
// - fetched word lands in data registers the cycle after the access
// - data registers hold the word until another read or a software write
`timescale 1ns/10ps
`default_nettype none
module pfsr_top
  import pfsr_pkg::*;
#(
  parameter int unsigned addr_hi_w = pfsr_hi_w
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [pfsr_pkg::pfsr_addr_w-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pfsr_pkg::pfsr_data_w-1:0] reg_wdata,
  output logic [pfsr_pkg::pfsr_data_w-1:0] reg_rdata,
  output logic instr_discard,
  output logic read_busy,
  input wire logic load_en,
  input wire logic [pfsr_pkg::pfsr_aw-1:0] load_addr,
  input wire logic [pfsr_pkg::pfsr_word_w-1:0] load_data
);
  import pfsr_pkg::*;

  function automatic logic hit(input logic [pfsr_addr_w-1:0] a,
                               input logic [pfsr_addr_w-1:0] off);
    hit = (a == off);
  endfunction : hit

  pfsr_state_t state;
  logic read_strobe;
  logic write_permit;
  logic [pfsr_data_w-1:0] flash_addr_low;
  logic [addr_hi_w-1:0] flash_addr_high;
  logic [pfsr_data_w-1:0] flash_data_low;
  logic [pfsr_dh_w-1:0] flash_data_high;
  logic land;
  logic slot_live;
  logic rd_live;
  logic start_read;
  logic wr_ctl;
  logic wr_al;
  logic wr_ah;
  logic wr_dl;
  logic wr_dh;

  // readback of one register; unimplemented bits and the unlock port read zero
  function automatic logic [pfsr_data_w-1:0] view(input logic [pfsr_addr_w-1:0] a);
    logic [pfsr_data_w-1:0] v;
    v = pfsr_rst_byte;
    case (a)
      pfsr_off_control: begin
        v[pfsr_bit_read] = read_strobe;
        v[pfsr_bit_permit] = write_permit;
      end
      pfsr_off_addr_low: begin
        v = flash_addr_low;
      end
      pfsr_off_addr_high: begin
        v[addr_hi_w-1:0] = flash_addr_high;
      end
      pfsr_off_data_low: begin
        v = flash_data_low;
      end
      pfsr_off_data_high: begin
        v[pfsr_dh_w-1:0] = flash_data_high;
      end
      default: begin
        v = pfsr_rst_byte;
      end
    endcase
    view = v;
  endfunction : view

  pfsr_mem_if #(.aw(pfsr_aw), .dw(pfsr_word_w)) mem_bus ();

  pfsr_array #(.aw(pfsr_aw), .dw(pfsr_word_w)) u_array (
    .clk_sys(clk_sys),
    .load_en(load_en),
    .load_addr(load_addr),
    .load_data(load_data),
    .port(mem_bus.mem)
  );

  // the dropped slot belongs to the array, so its register access must not land
  assign slot_live = !instr_discard;
  assign wr_ctl = reg_wr && slot_live && hit(reg_addr, pfsr_off_control);
  assign wr_al = reg_wr && slot_live && hit(reg_addr, pfsr_off_addr_low);
  assign wr_ah = reg_wr && slot_live && hit(reg_addr, pfsr_off_addr_high);
  assign wr_dl = reg_wr && slot_live && hit(reg_addr, pfsr_off_data_low);
  assign wr_dh = reg_wr && slot_live && hit(reg_addr, pfsr_off_data_high);
  assign rd_live = reg_rd && slot_live;
  // a strobe while busy is dropped, not queued
  assign start_read = wr_ctl && reg_wdata[pfsr_bit_read] && (state == pfsr_idle);

  // address bytes are plain storage, loaded before the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_addr_low <= pfsr_rst_byte;
    end else if (wr_al) begin
      flash_addr_low <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_addr_high <= '0;
    end else if (wr_ah) begin
      flash_addr_high <= reg_wdata[addr_hi_w-1:0];
    end
  end

  // read strobe reads back as pending until the word has landed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      read_strobe <= 1'b0;
    end else if (start_read) begin
      read_strobe <= 1'b1;
    end else if (land) begin
      read_strobe <= 1'b0;
    end
  end

  // permit bit is only stored; the erase and write sequence lives elsewhere
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      write_permit <= 1'b0;
    end else if (wr_ctl) begin
      write_permit <= reg_wdata[pfsr_bit_permit];
    end
  end

  // strobe cycle -> first slot runs -> access slot is dropped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= pfsr_idle;
    end else begin
      case (state)
        pfsr_idle: begin
          if (start_read) begin
            state <= pfsr_wait;
          end
        end
        pfsr_wait: begin
          state <= pfsr_access;
        end
        pfsr_access: begin
          state <= pfsr_idle;
        end
        default: begin
          state <= pfsr_idle;
        end
      endcase
    end
  end

  // array data come out of a register, so the read launches in the first slot;
  // the word stands through the access slot and lands at its closing edge.
  // limitation: an address write in the first slot is too late for this read
  assign mem_bus.rd_en = (state == pfsr_wait);
  assign mem_bus.addr = {flash_addr_high[pfsr_hi_w-1:0], flash_addr_low};
  assign instr_discard = (state == pfsr_access);
  assign read_busy = (state != pfsr_idle);
  assign land = (state == pfsr_access);

  // a landing word beats a software write; the slot gate already blocks one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_data_low <= pfsr_rst_byte;
    end else if (land) begin
      flash_data_low <= mem_bus.rdata[pfsr_data_w-1:0];
    end else if (wr_dl) begin
      flash_data_low <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_data_high <= '0;
    end else if (land) begin
      flash_data_high <= mem_bus.rdata[pfsr_word_w-1:pfsr_data_w];
    end else if (wr_dh) begin
      flash_data_high <= reg_wdata[pfsr_dh_w-1:0];
    end
  end

  // registered read data, held until the next live read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= pfsr_rst_byte;
    end else if (rd_live) begin
      reg_rdata <= view(reg_addr);
    end
  end
endmodule : pfsr_top
`default_nettype wire

// ### shared/pfsr_pkg.sv
// constants for the program flash self-read path
package pfsr_pkg;
  localparam int unsigned pfsr_addr_w = 8;
  localparam int unsigned pfsr_data_w = 8;
  localparam int unsigned pfsr_word_w = 14;
  localparam int unsigned pfsr_aw = 11;
  localparam int unsigned pfsr_hi_w = 3;
  localparam int unsigned pfsr_dh_w = 6;
  localparam logic [7:0] pfsr_off_control = 8'h98;
  localparam logic [7:0] pfsr_off_unlock = 8'h99;
  localparam logic [7:0] pfsr_off_addr_low = 8'h9a;
  localparam logic [7:0] pfsr_off_addr_high = 8'h9b;
  localparam logic [7:0] pfsr_off_data_low = 8'h9c;
  localparam logic [7:0] pfsr_off_data_high = 8'h9d;
  localparam int unsigned pfsr_bit_read = 0;
  localparam int unsigned pfsr_bit_wr = 1;
  localparam int unsigned pfsr_bit_permit = 2;
  localparam logic [7:0] pfsr_rst_byte = 8'h00;
  typedef enum logic [1:0] {
    pfsr_idle = 2'b00,
    pfsr_wait = 2'b01,
    pfsr_access = 2'b11
  } pfsr_state_t;
endpackage : pfsr_pkg

// ### shared/pfsr_mem_if.sv
// read port between controller and program array
`timescale 1ns/10ps
`default_nettype none
interface pfsr_mem_if #(
  parameter int unsigned aw = 11,
  parameter int unsigned dw = 14
);
  logic rd_en;
  logic [aw-1:0] addr;
  logic [dw-1:0] rdata;
  modport ctrl (output rd_en, output addr, input rdata);
  modport mem (input rd_en, input addr, output rdata);
endinterface : pfsr_mem_if
`default_nettype wire

// ### src/pfsr_array.sv
// program word array with registered read data
`timescale 1ns/10ps
`default_nettype none
module pfsr_array #(
  parameter int unsigned aw = 11,
  parameter int unsigned dw = 14
) (
  input wire logic clk_sys,
  input wire logic load_en,
  input wire logic [aw-1:0] load_addr,
  input wire logic [dw-1:0] load_data,
  pfsr_mem_if.mem port
);
  logic [dw-1:0] store [0:(1<<aw)-1];
  // contents come from the load port; erase/write sequencing lives elsewhere
  always_ff @(posedge clk_sys) begin
    if (load_en) begin
      store[load_addr] <= load_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (port.rd_en) begin
      port.rdata <= store[port.addr];
    end
  end
endmodule : pfsr_array
`default_nettype wire

// ### test/pfsr_asserts.sv
// port checker for the flash self-read path
`timescale 1ns/10ps
`default_nettype none
module pfsr_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic instr_discard,
  input wire logic read_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a strobe while busy is ignored, so only an idle one counts
  sequence strobe_s;
    reg_wr && reg_addr == 8'h98 && reg_wdata[0] && !read_busy;
  endsequence
  a_busy_two_cycles: assert property (strobe_s |=> read_busy [*2] ##1 !read_busy)
    else $error("busy window length off");
  a_first_slot_runs: assert property (strobe_s |=> !instr_discard)
    else $error("first slot dropped");
  a_second_slot_drop: assert property (strobe_s |-> ##2 instr_discard ##1 !instr_discard)
    else $error("second slot not dropped");
  a_drop_in_access: assert property (instr_discard |-> read_busy && $past(read_busy))
    else $error("drop outside access");
  a_strobe_reads_set: assert property (strobe_s ##1 (reg_rd && reg_addr == 8'h98) |=> reg_rdata[0])
    else $error("strobe bit not pending");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_drop_no_read: assert property (instr_discard |=> $stable(reg_rdata))
    else $error("dropped slot changed read data");
endmodule : pfsr_asserts
bind pfsr_top pfsr_asserts i_pfsr_asserts (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .instr_discard, .read_busy);
`default_nettype wire

// ### test/pfsr_core_model.sv
// core model issuing one register instruction per cycle
`timescale 1ns/10ps
`default_nettype none
module pfsr_core_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // strobes stay up until the next op call changes them; caller orders address before strobe
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
  endtask : op
endmodule : pfsr_core_model
`default_nettype wire

// ### test/pfsr_top_tb_top.sv
// self-checking bench for the flash self-read path
`timescale 1ns/10ps
`default_nettype none
module pfsr_top_tb_top;
  logic clk_sys = 0;
  logic rst_b = 0;
  logic load_en = 0;
  logic [10:0] load_addr = '0;
  logic [13:0] load_data = '0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, instr_discard, read_busy;
  int n_errors = 0;
  int checked = 0;
  always #4 clk_sys = ~clk_sys;
  pfsr_core_model i_pfsr_core_model (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  pfsr_top i_pfsr_top (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .instr_discard, .read_busy, .load_en, .load_addr, .load_data);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pfsr_core_model.op(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_pfsr_core_model.op(1'b0, 1'b1, a, 8'h00);
    i_pfsr_core_model.op(1'b0, 1'b0, a, 8'h00);
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd
  task automatic lw(input logic [10:0] a, input logic [13:0] d);
    @(posedge clk_sys);
    #1;
    {load_en, load_addr, load_data} = {1'b1, a, d};
  endtask : lw
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    lw(11'h7ff, 14'h2a5c);
    lw(11'h000, 14'h1234);
    @(posedge clk_sys);
    #1 load_en = 0;
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1;
    for (int i = 0; i < 6; i++) rd(8'h98 + 8'(i), 8'h00);
    wr(8'h9b, 8'hff);
    wr(8'h9a, 8'hff);
    rd(8'h9b, 8'h07);
    wr(8'h98, 8'h01);
    rd(8'h98, 8'h01);
    chk("instr_discard", {7'h0, instr_discard}, 8'h01);
    rd(8'h98, 8'h00);
    rd(8'h9c, 8'h5c);
    rd(8'h9d, 8'h2a);
    wr(8'h9a, 8'h00);
    rd(8'h9c, 8'h5c);
    wr(8'h9c, 8'ha5);
    rd(8'h9c, 8'ha5);
    wr(8'h98, 8'h04);
    rd(8'h98, 8'h04);
    wr(8'h99, 8'hff);
    rd(8'h99, 8'h00);
    wr(8'h9b, 8'h00);
    wr(8'h98, 8'h01);
    wr(8'h98, 8'h01);
    chk("read_busy", {7'h0, read_busy}, 8'h01);
    wr(8'h9a, 8'h55);
    chk("instr_discard", {7'h0, instr_discard}, 8'h01);
    i_pfsr_core_model.op(1'b0, 1'b0, 8'h00, 8'h00);
    chk("read_busy", {7'h0, read_busy}, 8'h00);
    rd(8'h9a, 8'h00);
    rd(8'h9c, 8'h34);
    rd(8'h9d, 8'h12);
    complete_run();
  end
endmodule : pfsr_top_tb_top
`default_nettype wire
